// [rtl/udbp_pkg.sv]
// Shared types and timing constants for the burst protocol engine
package udbp_pkg;

    // Clock period in ns
    localparam int CLK_NS = 8;

    // Minimum strobe cycle per mode, ns
    localparam int TCYC_M0_NS = 112;
    localparam int TCYC_M1_NS = 73;
    localparam int TCYC_M2_NS = 54;
    localparam int TCYC_M3_NS = 39;
    localparam int TCYC_M4_NS = 25;

    // Ready-to-pause per mode, ns
    localparam int TRP_M0_NS = 160;
    localparam int TRP_M1_NS = 125;
    localparam int TRP_M2_NS = 100;

    // Strobe edge to termination request, ns
    localparam int TSS_NS = 50;

    // Trailing words a paused recipient must still accept
    localparam int TRAIL_LO = 2;
    localparam int TRAIL_HI = 3;

    // Mode field
    localparam int MODE_W = 3;
    localparam logic [2:0] MODE_RST = 3'h0;

    // Least-time rounding to whole cycles, at least one
    function automatic logic [7:0] ns2cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        if (c < 1) c = 1;
        return c[7:0];
    endfunction

    typedef struct packed {
        logic [15:0] data;
        logic        last;
    } udbp_word_t;

    // Link pins, device view
    typedef struct packed {
        logic        ack_n;
        logic        stop;
        logic        hrdy_n;
        logic        hstrobe;
        logic [15:0] dq;
    } udbp_link_in_t;

endpackage : udbp_pkg

// [rtl/udbp_buf2.sv]
// Two-entry valid/ready buffer
`timescale 1ns/10ps
`default_nettype none
module udbp_buf2 #(
    parameter int W = 17
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              rd;
        logic              wr;
        logic [1:0]        cnt;
    } udbp_buf_st_t;

    udbp_buf_st_t st_ff;
    udbp_buf_st_t nxt_st;
    logic         push;
    logic         pop;

    assign in_ready_o  = (st_ff.cnt != 2'h2);
    assign out_valid_o = (st_ff.cnt != 2'h0);
    assign out_data_o  = st_ff.mem[st_ff.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data_i;
            nxt_st.wr = ~st_ff.wr;
        end
        if (pop) begin
            nxt_st.rd = ~st_ff.rd;
        end
        nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule // udbp_buf2
`default_nettype wire

// [rtl/udbp_engine.sv]
// Device-side burst engine: request, strobe, pause and termination
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - A burst lasts from acknowledge assertion until acknowledge negation.
// - Paused recipient still takes two trailing words, three from mode 3 (code keeps one buffer slot free; trail is unused).
// - Initiation runs from request raised to first data strobe edge.
// - Only the device starts a burst, by raising its request.
// - Data-in: drive bus only with acknowledge, no stop, host ready.
// - Request and device ready stay unchanged until first strobe edge (code: data-out stop_req_i before the first edge negates ready, drops request).
// - Recipient pauses by negating ready and resumes by asserting it.
// - Sender pauses by withholding strobe edges, resumes by strobing.
// - Recipient negates ready and waits ready-to-pause before terminating.
// - Strobe edges never closer than the mode's minimum cycle.
// - Burst end is not command end; later bursts may continue.
// - Recipient pauses first; either side may terminate.
// - Host stop terminates; device acknowledges by dropping request.
// - Device drops request to terminate; host acknowledges with stop.
// - Terminating sender freezes strobe, then returns it asserted without data.
// - Sender seeing termination returns strobe asserted, no data, no CRC.
// - After recipient requests termination its ready stays negated.
// - Recipient ignores strobe edges while request low or stop high.
// - Data latched on both strobe edges, strobe driven by data driver.
// - Both sides run CRC; device compares host CRC and flags mismatch (code compares on data-out bursts only).
// - Shared lines revert to normal meanings when acknowledge negates.
module udbp_engine #(
    parameter int DEPTH_W = 16
) (
    input  wire logic                   clk_i,
    input  wire logic                   rstn_i,
    input  wire logic [2:0]             mode_i,
    input  wire logic                   dir_in_i,
    input  wire logic                   xfer_req_i,
    input  wire logic                   stop_req_i,
    input  wire logic                   tx_valid_i,
    output logic                        tx_ready_o,
    input  wire logic [15:0]            tx_data_i,
    output logic                        rx_valid_o,
    input  wire logic                   rx_ready_i,
    output logic [15:0]                 rx_data_o,
    input  wire udbp_pkg::udbp_link_in_t link_i,
    output logic                        dmarq_o,
    output logic                        drdy_n_o,
    output logic                        dstrobe_o,
    output logic [15:0]                 dq_o,
    output logic                        dq_oe_o,
    output logic                        busy_o,
    output logic                        crc_err_o
);
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_REQ  = 6'h02,
        S_XFER = 6'h04,
        S_PAUS = 6'h08,
        S_TERM = 6'h10,
        S_CRC  = 6'h20
    } udbp_state_t;

    typedef struct packed {
        udbp_state_t   state;
        logic [1:0][4:0] sy;     // ack_n, stop, hrdy_n, hstrobe, spare
        logic [1:0][15:0] dsy;
        logic          hs_last;
        logic          started;
        logic          dev_term;
        logic [7:0]    tmr;
        logic [15:0]   crc;
        logic          dmarq;
        logic          drdy_n;
        logic          dstrobe;
        logic [15:0]   dq;
        logic          dq_oe;
        logic          busy;
        logic          crc_err;
        logic          txr;
    } udbp_st_t;

    udbp_st_t   st_ff;
    udbp_st_t   nxt_st;
    logic       ack, stop, hrdy, hs;
    logic       hs_edge;
    logic       rx_in_ready;
    logic       rx_room;
    logic       rx_push;
    logic [7:0] cyc_min;
    logic [7:0] rp_min;
    logic [7:0] ss_min;
    logic [1:0] trail;

    // Mode to cycle counts, rounded up
    function automatic logic [7:0] tcyc(input logic [2:0] m);
        unique case (m)
            3'h0:    return udbp_pkg::ns2cyc(udbp_pkg::TCYC_M0_NS);
            3'h1:    return udbp_pkg::ns2cyc(udbp_pkg::TCYC_M1_NS);
            3'h2:    return udbp_pkg::ns2cyc(udbp_pkg::TCYC_M2_NS);
            3'h3:    return udbp_pkg::ns2cyc(udbp_pkg::TCYC_M3_NS);
            default: return udbp_pkg::ns2cyc(udbp_pkg::TCYC_M4_NS);
        endcase
    endfunction

    function automatic logic [7:0] trp(input logic [2:0] m);
        unique case (m)
            3'h0:    return udbp_pkg::ns2cyc(udbp_pkg::TRP_M0_NS);
            3'h1:    return udbp_pkg::ns2cyc(udbp_pkg::TRP_M1_NS);
            default: return udbp_pkg::ns2cyc(udbp_pkg::TRP_M2_NS);
        endcase
    endfunction

    // CRC-16, poly 0x1021, one word
    function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                            input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            if (r[15] ^ d[i]) r = {r[14:0], 1'b0} ^ 16'h1021;
            else              r = {r[14:0], 1'b0};
        end
        return r;
    endfunction

    assign cyc_min = tcyc(mode_i);
    assign rp_min  = trp(mode_i);
    assign ss_min  = udbp_pkg::ns2cyc(udbp_pkg::TSS_NS);
    assign trail   = (mode_i >= 3'h3) ? 2'(udbp_pkg::TRAIL_HI)
                                      : 2'(udbp_pkg::TRAIL_LO);

    // Second stage of synchronisers only
    assign ack  = !st_ff.sy[1][4];
    assign stop = st_ff.sy[1][3];
    assign hrdy = !st_ff.sy[1][2];
    assign hs   = st_ff.sy[1][1];
    assign hs_edge = (hs != st_ff.hs_last);
    // Pause while a word waits so one slot stays free for trailing words
    assign rx_room = !rx_valid_o || rx_ready_i;

    // Recipient accepts only while request high and stop low
    assign rx_push = dir_in_i == 1'b0 && hs_edge && st_ff.dmarq && !stop
                     && (st_ff.state == S_XFER || st_ff.state == S_PAUS);

    udbp_buf2 #(
        .W(16)
    ) u_rxbuf (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .in_valid_i (rx_push),
        .in_ready_o (rx_in_ready),
        .in_data_i  (st_ff.dsy[1]),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o (rx_data_o)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sy[0] = {link_i.ack_n, link_i.stop, link_i.hrdy_n,
                        link_i.hstrobe, 1'b0};
        nxt_st.sy[1] = st_ff.sy[0];
        nxt_st.dsy[0] = link_i.dq;
        nxt_st.dsy[1] = st_ff.dsy[0];
        nxt_st.hs_last = hs;
        nxt_st.txr = 1'b0;
        if (st_ff.tmr != 8'h00) nxt_st.tmr = st_ff.tmr - 8'h01;
        unique case (st_ff.state)
            S_IDLE: begin
                nxt_st.dq_oe = 1'b0;
                nxt_st.dstrobe = 1'b1;
                nxt_st.drdy_n = 1'b1;
                if (xfer_req_i && !ack) begin
                    nxt_st.dmarq = 1'b1;
                    nxt_st.busy = 1'b1;
                    nxt_st.started = 1'b0;
                    nxt_st.dev_term = 1'b0;
                    nxt_st.crc = 16'h4abb;
                    nxt_st.state = S_REQ;
                end
            end
            S_REQ: begin
                // Request held until acknowledge; a data-out stop_req_i can drop it before the first edge
                if (!dir_in_i) nxt_st.drdy_n = !ack;
                if (ack) begin
                    if (dir_in_i && !stop && hrdy) begin
                        nxt_st.dq_oe = 1'b1;
                        nxt_st.tmr = cyc_min;
                        nxt_st.state = S_XFER;
                    end else if (!dir_in_i) begin
                        nxt_st.state = S_XFER;
                    end
                end
            end
            S_XFER: begin
                if (dir_in_i) begin
                    if (stop || !hrdy) begin
                        // Host stop or host pause: freeze strobe
                        nxt_st.state = stop ? S_TERM : S_XFER;
                        if (stop) nxt_st.dmarq = 1'b0;
                    end else if (stop_req_i && st_ff.started
                                 && st_ff.tmr == 8'h00) begin
                        nxt_st.dmarq = 1'b0;
                        nxt_st.dev_term = 1'b1;
                        nxt_st.state = S_TERM;
                    end else if (st_ff.tmr == 8'h00 && tx_valid_i) begin
                        nxt_st.dq = tx_data_i;
                        nxt_st.dstrobe = ~st_ff.dstrobe;
                        nxt_st.crc = crc_upd(st_ff.crc, tx_data_i);
                        nxt_st.txr = 1'b1;
                        nxt_st.started = 1'b1;
                        nxt_st.tmr = cyc_min;
                    end
                end else begin
                    if (rx_push) begin
                        nxt_st.started = 1'b1;
                        nxt_st.crc = crc_upd(st_ff.crc, st_ff.dsy[1]);
                    end
                    if (stop) begin
                        nxt_st.dmarq = 1'b0;
                        nxt_st.state = S_TERM;
                    end else if (!rx_room || stop_req_i) begin
                        // Pause first; with a word waiting only one buffer slot is left for trailing words
                        nxt_st.drdy_n = 1'b1;
                        nxt_st.tmr = rp_min;
                        nxt_st.state = S_PAUS;
                    end
                end
            end
            S_PAUS: begin
                if (rx_push) nxt_st.crc = crc_upd(st_ff.crc, st_ff.dsy[1]);
                if (stop) begin
                    nxt_st.dmarq = 1'b0;
                    nxt_st.state = S_TERM;
                end else if (stop_req_i && st_ff.tmr == 8'h00) begin
                    nxt_st.dmarq = 1'b0;
                    nxt_st.dev_term = 1'b1;
                    nxt_st.state = S_TERM;
                end else if (!stop_req_i && rx_room) begin
                    nxt_st.drdy_n = 1'b0;
                    nxt_st.state = S_XFER;
                end
            end
            S_TERM: begin
                // Ready stays negated to burst end
                if (!dir_in_i) nxt_st.drdy_n = 1'b1;
                if (dir_in_i && stop) begin
                    nxt_st.dstrobe = 1'b1;
                end
                if (!ack) begin
                    nxt_st.dq_oe = 1'b0;
                    nxt_st.state = dir_in_i ? S_IDLE : S_CRC;
                    if (dir_in_i) nxt_st.busy = 1'b0;
                end
            end
            S_CRC: begin
                // Host CRC sampled on acknowledge negation
                if (st_ff.dsy[1] != st_ff.crc) nxt_st.crc_err = 1'b1;
                nxt_st.busy = 1'b0;
                nxt_st.drdy_n = 1'b1;
                nxt_st.state = S_IDLE;
            end
            default: nxt_st.state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // Idle pin levels, so no false strobe edge follows reset
            st_ff <= '{state: S_IDLE, sy: '{default: 5'h16},
                       hs_last: 1'b1,
                       dmarq: 1'b0, drdy_n: 1'b1, dstrobe: 1'b1,
                       default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tx_ready_o = st_ff.txr;
    assign dmarq_o    = st_ff.dmarq;
    assign drdy_n_o   = st_ff.drdy_n;
    assign dstrobe_o  = st_ff.dstrobe;
    assign dq_o       = st_ff.dq;
    assign dq_oe_o    = st_ff.dq_oe;
    assign busy_o     = st_ff.busy;
    assign crc_err_o  = st_ff.crc_err;

    // Assertions
    logic [7:0] gap_cnt;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) gap_cnt <= 8'hff;
        else if ($changed(dstrobe_o) && dq_oe_o) gap_cnt <= 8'h00;
        else if (gap_cnt != 8'hff) gap_cnt <= gap_cnt + 8'h01;
    end

    a_strobe_min_gap: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ($changed(dstrobe_o) && st_ff.state == S_XFER && $past(st_ff.started))
        |-> gap_cnt + 8'h01 >= cyc_min)
        else $error("Strobe edges too close");
    a_req_hold_init: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (st_ff.state == S_REQ) |=> dmarq_o)
        else $error("Request dropped during initiation");
    a_drive_needs_ack: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(dq_oe_o) |-> $past(ack && !stop && hrdy && dir_in_i))
        else $error("Bus driven without permission");
    a_stop_drops_req: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (stop && st_ff.state == S_XFER) |=> !dmarq_o)
        else $error("Host stop not acknowledged");
    a_ready_stays_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (st_ff.state == S_TERM && !dir_in_i) |=> drdy_n_o)
        else $error("Ready reasserted after termination");
    a_pause_before_term: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ($past(st_ff.state) == S_PAUS && st_ff.state == S_TERM && !dir_in_i)
        |-> drdy_n_o)
        else $error("Termination without pause");
    a_no_rx_when_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
        stop |-> !rx_push)
        else $error("Strobe taken under stop");
    a_start_only_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(dmarq_o) |-> $past(st_ff.state) == S_IDLE && $past(xfer_req_i))
        else $error("Request raised without cause");
endmodule // udbp_engine
`default_nettype wire

// [test/udbp_host_model.sv]
// Host-side partner model of the burst link
`timescale 1ns/10ps
`default_nettype none
module udbp_host_model (
    input  wire logic               lclk_i,
    input  wire logic               dmarq_i,
    input  wire logic               drdy_n_i,
    input  wire logic               dstrobe_i,
    input  wire logic [15:0]        dq_i,
    input  wire logic               dq_oe_i,
    output var udbp_pkg::udbp_link_in_t link_o
);
    logic        ack_n = 1'b1;
    logic        stop = 1'b0;
    logic        hrdy_n = 1'b1;
    logic        hstb = 1'b1;
    logic        h_oe = 1'b0;
    logic [15:0] h_dq = 16'h0;
    logic [15:0] last = 16'h0;
    logic [15:0] crc = 16'h0;
    logic [15:0] rxq[$];
    int          bad = 0;
    realtime     t_last = 0;
    realtime     gap = 1e9;
    // Released bus shows the inverse of its last value, not a stale copy
    always @(posedge lclk_i) if (h_oe | dq_oe_i) last <= link_o.dq;
    assign link_o = '{ack_n, stop, hrdy_n, hstb,
                      h_oe ? h_dq : (dq_oe_i ? dq_i : ~last)};
    // Sample after the edge's time step so data and strobe have both settled
    always @(dstrobe_i) begin
        #1;
        if (!ack_n && !stop && dmarq_i && dq_oe_i) begin
            rxq.push_back(dq_i);
            if ($realtime - t_last < gap) gap = $realtime - t_last;
            t_last = $realtime;
        end
    end
    always @(posedge dq_oe_i) if (ack_n || stop || hrdy_n) bad++;
    function automatic logic [15:0] crc_upd(logic [15:0] c, logic [15:0] d);
        for (int i = 15; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
        return c;
    endfunction
    task automatic wait_rq(input logic v);
        repeat (300) if (dmarq_i !== v) @(posedge lclk_i);
        if (dmarq_i !== v) bad++;
    endtask
    task automatic wait_cnt(input int k);
        repeat (600) if (rxq.size() < k) @(posedge lclk_i);
    endtask
    task automatic burst_out(input int n, input logic [15:0] base,
                             input logic corrupt);
        crc = 16'h4abb;
        wait_rq(1'b1);
        @(posedge lclk_i);
        ack_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            // Hold the word back while the device has paused us
            repeat (300) if (drdy_n_i) @(posedge lclk_i);
            @(posedge lclk_i);
            h_oe = 1'b1;
            h_dq = base + i[15:0];
            crc = crc_upd(crc, h_dq);
            @(negedge lclk_i);
            hstb = ~hstb;
        end
        wait_rq(1'b0);
        @(posedge lclk_i);
        stop = 1'b1;
        hstb = 1'b1;
        h_dq = crc ^ {15'h0, corrupt};
        @(posedge lclk_i);
        ack_n = 1'b1;
        @(posedge lclk_i);
        h_oe = 1'b0;
        stop = 1'b0;
    endtask
    task automatic burst_in(input int n, input int p);
        wait_rq(1'b1);
        @(posedge lclk_i);
        rxq = {};
        gap = 1e9;
        t_last = -1e6;
        ack_n = 1'b0;
        hrdy_n = 1'b0;
        wait_cnt(p);
        hrdy_n = 1'b1;
        repeat (6) @(posedge lclk_i);
        hrdy_n = 1'b0;
        wait_cnt(n);
        repeat (3) @(posedge lclk_i);
        stop = 1'b1;
        wait_rq(1'b0);
        @(posedge lclk_i);
        hrdy_n = 1'b1;
        ack_n = 1'b1;
        @(posedge lclk_i);
        stop = 1'b0;
    endtask
endmodule // udbp_host_model
`default_nettype wire

// [test/udbp_engine_tb_top.sv]
// Testbench for the device-side burst engine
`timescale 1ns/10ps
`default_nettype none
module udbp_engine_tb_top;
    logic clk_i = 0, rstn_i = 0, lclk = 0, dir_in_i = 0;
    logic xfer_req_i = 0, stop_req_i = 0, tx_valid_i = 0, rx_ready_i = 1;
    logic [2:0]  mode_i = 3'h0;
    logic [15:0] tx_data_i = 16'h0;
    logic        tx_ready_o, rx_valid_o, dmarq_o, drdy_n_o, dstrobe_o;
    logic        dq_oe_o, busy_o, crc_err_o;
    logic [15:0] rx_data_o, dq_o;
    udbp_pkg::udbp_link_in_t link;
    logic [15:0] got[$];
    int n_errors = 0, compares = 0;
    int tcyc[5] = '{udbp_pkg::TCYC_M0_NS, udbp_pkg::TCYC_M1_NS,
        udbp_pkg::TCYC_M2_NS, udbp_pkg::TCYC_M3_NS, udbp_pkg::TCYC_M4_NS};
    initial forever #4 clk_i = ~clk_i;
    // Odd offset keeps the link time base unrelated to the core clock
    initial begin
        #13;
        forever #40 lclk = ~lclk;
    end
    udbp_engine udbp_engine_i (.clk_i(clk_i), .rstn_i(rstn_i),
        .mode_i(mode_i), .dir_in_i(dir_in_i), .xfer_req_i(xfer_req_i),
        .stop_req_i(stop_req_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i),
        .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
        .rx_data_o(rx_data_o), .link_i(link), .dmarq_o(dmarq_o),
        .drdy_n_o(drdy_n_o), .dstrobe_o(dstrobe_o), .dq_o(dq_o),
        .dq_oe_o(dq_oe_o), .busy_o(busy_o), .crc_err_o(crc_err_o));
    udbp_host_model udbp_host_model_i (.lclk_i(lclk), .dmarq_i(dmarq_o),
        .drdy_n_i(drdy_n_o), .dstrobe_i(dstrobe_o), .dq_i(dq_o),
        .dq_oe_i(dq_oe_o), .link_o(link));
    always @(negedge clk_i) if (rx_valid_o && rx_ready_i) got.push_back(rx_data_o);
    task automatic end_of_test;
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wt(input string nm, ref logic s, input logic v);
        repeat (3000) begin
            @(negedge clk_i);
            if (s === v) break;
        end
        cmp(nm, {15'h0, v}, {15'h0, s});
    endtask
    task automatic start(input logic dir, input logic [2:0] m);
        mode_i = m;
        dir_in_i = dir;
        xfer_req_i = 1'b1;
        wt("dmarq_on", dmarq_o, 1'b1);
        xfer_req_i = 1'b0;
    endtask
    task automatic t_reset;
        repeat (20) @(negedge clk_i);
        cmp("idle_pins", 16'h0018, {10'h0, dmarq_o, drdy_n_o, dstrobe_o,
            dq_oe_o, busy_o, crc_err_o});
    endtask
    task automatic t_data_in(input logic [2:0] m);
        fork
            udbp_host_model_i.burst_in(8, 3);
            begin
                start(1'b1, m);
                for (int i = 0; i < 8; i++) begin
                    tx_valid_i = 1'b1;
                    tx_data_i = 16'ha5c0 + i[15:0];
                    wt("tx_take", tx_ready_o, 1'b1);
                end
                tx_valid_i = 1'b0;
                wt("dmarq_off", dmarq_o, 1'b0);
                wt("busy_off", busy_o, 1'b0);
            end
        join
        cmp("in_count", 16'd8, udbp_host_model_i.rxq.size());
        for (int i = 0; i < 8; i++)
            cmp("in_word", 16'ha5c0 + i[15:0], udbp_host_model_i.rxq[i]);
        cmp("in_gap", 16'h1, {15'h0, udbp_host_model_i.gap >= tcyc[m]});
    endtask
    task automatic t_data_out(input logic [2:0] m, input int n,
                              input logic stall, input logic corrupt);
        realtime t0;
        int trp;
        trp = (m == 3'h0) ? udbp_pkg::TRP_M0_NS
            : (m == 3'h1) ? udbp_pkg::TRP_M1_NS : udbp_pkg::TRP_M2_NS;
        got = {};
        rx_ready_i = !stall;
        fork
            udbp_host_model_i.burst_out(n, 16'h3c00, corrupt);
            begin
                start(1'b0, m);
                wt("rdy_on", drdy_n_o, 1'b0);
                if (stall) begin
                    wt("rdy_pause", drdy_n_o, 1'b1);
                    rx_ready_i = 1'b1;
                end
                repeat (4000) if (got.size() < n) @(negedge clk_i);
                stop_req_i = 1'b1;
                wt("rdy_neg", drdy_n_o, 1'b1);
                t0 = $realtime;
                wt("dmarq_off", dmarq_o, 1'b0);
                cmp("trp_wait", 16'h1, {15'h0, ($realtime - t0) >= trp});
                stop_req_i = 1'b0;
                wt("busy_off", busy_o, 1'b0);
                cmp("rdy_held", 16'h1, {15'h0, drdy_n_o});
            end
        join
        cmp("out_count", n[15:0], got.size());
        for (int i = 0; i < n; i++)
            cmp("out_word", 16'h3c00 + i[15:0], got[i]);
        cmp("crc_flag", {15'h0, corrupt}, {15'h0, crc_err_o});
    endtask
    initial begin
        #300000;
        n_errors++;
        $display("[ERR] watchdog exp done got hang");
        end_of_test();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        rstn_i = 1'b1;
        t_reset();
        t_data_in(3'h0);
        t_data_in(3'h4);
        t_data_out(3'h1, 6, 1'b0, 1'b0);
        t_data_out(3'h4, 7, 1'b1, 1'b0);
        t_data_out(3'h2, 4, 1'b0, 1'b1);
        cmp("host_view", 16'h0, udbp_host_model_i.bad[15:0]);
        end_of_test();
    end
endmodule // udbp_engine_tb_top
`default_nettype wire
